// ===== bench/flash_id_powerdown_secreg_read_tb.sv
`timescale 1ns/100ps
`define CK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module flash_id_powerdown_secreg_read_tb;
  // id values are arbitrary
  localparam logic [7:0] MK = 8'h5a, DV = 8'h41, MT = 8'h3c, DN = 8'h11, SG = 8'h42;
  logic core_clk = 0, sys_rst = 1, load_en = 0, op_busy = 0, cmd_valid = 0, rd_ready = 1;
  logic [11:0] load_addr = 0, cmd_len = 0;
  logic [7:0] load_data = 0, cmd_op = 0, rd_data;
  logic [23:0] cmd_addr = 0;
  logic asleep, power_changing, cmd_ready, rd_valid;
  logic [7:0] q [$];
  int error_cnt = 0, compares = 0, cyc = 0;
  fsid_link_if fsid_link_if_inst ();
  fsid_dev #(.MAKER_ID(MK), .DEV_ID(DV), .MEM_TYPE(MT), .DENSITY(DN), .SIG_ID(SG),
    .ENTRY_CYC(4), .EXIT_CYC(6)) fsid_dev_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(fsid_link_if_inst), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .op_busy(op_busy), .asleep(asleep),
    .power_changing(power_changing));
  fsid_host #(.ENTRY_CYC(4), .EXIT_CYC(6)) fsid_host_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .link(fsid_link_if_inst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  fsid_link_monitor fsid_link_monitor_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .cs_n(fsid_link_if_inst.cs_n), .sclk(fsid_link_if_inst.sclk),
    .host_sio_o(fsid_link_if_inst.host_sio_o), .dev_sio_o(fsid_link_if_inst.dev_sio_o),
    .dev_sio_oe_n(fsid_link_if_inst.dev_sio_oe_n), .sio_clash(fsid_link_if_inst.sio_clash),
    .asleep(asleep), .power_changing(power_changing));
  // clock and hang guard
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      results();
    end
  end
  // collect read bytes
  always @(posedge core_clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) q.push_back(rd_data);
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [11:0] n);
    q = {};
    cmd_op = op; cmd_addr = a; cmd_len = n; cmd_valid = 1;
    @(posedge core_clk);
    while (cmd_ready !== 1'b1) @(posedge core_clk);
    #1 cmd_valid = 0;
    @(posedge core_clk);
    while (cmd_ready !== 1'b1) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    #1;
  endtask : run
  task load(input logic [11:0] a, input logic [7:0] d);
    load_addr = a; load_data = d; load_en = 1;
    @(posedge core_clk);
    #1;
  endtask : load
  task t_ids;
    logic [7:0] ops [3] = '{8'h90, 8'h92, 8'h94};
    foreach (ops[i]) for (int a = 0; a < 2; a++) begin
      run(ops[i], {16'h0, 7'h0, a[0]}, 3);
      `CK(q[0], a ? DV : MK)
      `CK(q[1], a ? MK : DV)
      `CK(q[2], a ? DV : MK)
    end
    run(8'h9f, 0, 3);
    `CK({q[0], q[1], q[2]}, {MK, MT, DN})
    $display("ids done");
  endtask : t_ids
  task t_sec;
    load(12'h3fe, 8'ha5); load(12'h3ff, 8'h5c); load(12'h000, 8'hc3); load(12'h800, 8'h7e);
    load_en = 0;
    rd_ready = 0;
    fork #60000 rd_ready = 1; join_none
    run(8'h48, 24'h0013fe, 34);
    `CK(q.size(), 34)
    `CK({q[0], q[1], q[2]}, {8'ha5, 8'h5c, 8'hc3})
    run(8'h48, 24'h003000, 1);
    `CK(q[0], 8'h7e)
    run(8'h48, 24'h004000, 1);
    `CK(q[0], 8'hff)
    $display("secure read done");
  endtask : t_sec
  task t_sleep;
    run(8'hb9, 0, 0); repeat (20) @(posedge core_clk); #1;
    `CK(asleep, 1'b1)
    run(8'h9f, 0, 2);
    `CK({q[0], q[1]}, 16'hffff)
    run(8'hab, 0, 0); repeat (20) @(posedge core_clk); #1;
    `CK(asleep, 1'b0)
    `CK(power_changing, 1'b0)
    run(8'hb9, 0, 0); repeat (20) @(posedge core_clk); #1;
    `CK(asleep, 1'b1)
    run(8'h66, 0, 0); run(8'h99, 0, 0);
    `CK(asleep, 1'b0)
    $display("sleep done");
  endtask : t_sleep
  task t_busy;
    op_busy = 1;
    run(8'h9f, 0, 1);
    `CK(q[0], 8'hff)
    run(8'hab, 0, 2);
    `CK({q[0], q[1]}, {SG, SG})
    op_busy = 0;
    $display("busy done");
  endtask : t_busy
  task results;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 0;
    `CK(asleep, 1'b0)
    t_ids(); t_sec(); t_sleep(); t_busy();
    results();
  end
endmodule : flash_id_powerdown_secreg_read_tb

// ===== bench/fsid_link_monitor.sv
`timescale 1ns/100ps
module fsid_link_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] host_sio_o,
  input wire logic [3:0] dev_sio_o,
  input wire logic [3:0] dev_sio_oe_n,
  input wire logic [3:0] sio_clash,
  input wire logic asleep,
  input wire logic power_changing
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // select held high long enough for release
  sequence cs_idle; cs_n [*5]; endsequence
  sequence sclk_up; $rose(sclk); endsequence
  lines_released_a: assert property (cs_idle |-> dev_sio_oe_n == 4'hf)
    else $error("device drives while deselected");
  no_clash_a: assert property (sio_clash == 4'h0)
    else $error("both ends drive a data line");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("link clock runs outside a frame");
  dev_hold_a: assert property (sclk_up |=> $stable(dev_sio_o) [*2])
    else $error("device data moves after a rising edge");
  host_fall_a: assert property ($changed(host_sio_o) |-> !sclk)
    else $error("host data moves while clock high");
  sleep_after_a: assert property ($rose(asleep) |-> $past(power_changing))
    else $error("sleep entered without entry delay");
  sleep_cs_a: assert property ($rose(power_changing) |-> cs_n)
    else $error("power change starts while selected");
  cs_gap_a: assert property ($rose(cs_n) |=> cs_n [*2])
    else $error("select high gap too short");
endmodule : fsid_link_monitor

// ===== logic/fsid_dev.sv
`timescale 1ns/100ps
module fsid_dev #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_ID = 8'h41, // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h3c, // arbitrary value
  parameter logic [7:0] DENSITY = 8'h11, // arbitrary value
  parameter logic [7:0] SIG_ID = 8'h42, // arbitrary value
  parameter int ENTRY_CYC = fsid_pkg::SLEEP_ENTRY_CYC,
  parameter int EXIT_CYC = fsid_pkg::WAKE_EXIT_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  fsid_link_if.dev link,
  input wire logic load_en,
  input wire logic [fsid_pkg::SEC_IDX_W-1:0] load_addr,
  input wire logic [7:0] load_data,
  input wire logic op_busy,
  output logic asleep,
  output logic power_changing
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic cs_m, cs_s, cs_d;
  logic sclk_m, sclk_s, sclk_d;
  logic [3:0] sio_m, sio_s;
  logic sclk_rise, sclk_fall, cs_rise;

  // two flops per pin, third flop only for edge finding
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      sio_m <= 4'h0;
      sio_s <= 4'h0;
    end else begin
      cs_m <= link.cs_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
      sclk_m <= link.sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sio_m <= link.sio;
      sio_s <= sio_m;
    end
  end

  // clock edges seen only while selected, select rise always
  assign sclk_rise = sclk_s & ~sclk_d & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_s;
  assign cs_rise = cs_s & ~cs_d;

  ////////////////////////////////////////////////////////////////////////////
  // frame state
  fsid_pkg::fsid_dev_st_t st, dec_st;
  logic [7:0] op, op_next;
  logic [5:0] tot;
  logic [4:0] cnt, dec_cnt;
  logic [2:0] lanes, dec_lanes;
  logic [23:0] addr;
  logic [7:0] shreg;
  logic [3:0] bits_left;
  logic [1:0] byte_cnt;
  logic id_alt;
  logic [7:0] out_byte;
  logic sec_hit;
  logic [1:0] sec_sel;
  logic [7:0] sec_mem [0:fsid_pkg::SEC_ENTRIES-1];
  logic armed, waking;
  logic [fsid_pkg::TIMER_W-1:0] timer;

  assign op_next = {op[6:0], sio_s[0]};

  // opcode decode at the eighth rising edge
  always_comb begin
    dec_st = fsid_pkg::DS_IGNORE;
    dec_cnt = 5'h0;
    dec_lanes = 3'h1;
    if (!asleep || op_next == fsid_pkg::WAKE_FROM_SLEEP_CMD) begin
      case (op_next)
        fsid_pkg::SECURE_AREA_READ_CMD: begin
          dec_st = fsid_pkg::DS_ADDR;
          dec_cnt = 5'(fsid_pkg::ADDR_BITS);
        end
        fsid_pkg::MAKER_DEVICE_ID_CMD: begin
          dec_st = fsid_pkg::DS_ADDR;
          dec_cnt = 5'(fsid_pkg::ADDR_BITS);
        end
        fsid_pkg::MAKER_DEVICE_ID_DUAL_CMD: begin
          dec_st = fsid_pkg::DS_ADDR;
          dec_cnt = 5'(fsid_pkg::ADDR_BITS);
          dec_lanes = 3'h2;
        end
        fsid_pkg::MAKER_DEVICE_ID_QUAD_CMD: begin
          dec_st = fsid_pkg::DS_ADDR;
          dec_cnt = 5'(fsid_pkg::ADDR_BITS);
          dec_lanes = 3'h4;
        end
        fsid_pkg::WAKE_FROM_SLEEP_CMD: begin
          dec_st = fsid_pkg::DS_DUMMY;
          dec_cnt = 5'(fsid_pkg::SIG_DUMMY_BITS);
        end
        fsid_pkg::THREE_BYTE_IDENT_CMD: begin
          dec_st = op_busy ? fsid_pkg::DS_IGNORE : fsid_pkg::DS_DATA;
        end
        default: begin
          dec_st = fsid_pkg::DS_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= fsid_pkg::DS_OPC;
      op <= 8'h00;
      tot <= 6'h0;
      cnt <= 5'h0;
      lanes <= 3'h1;
      addr <= 24'h000000;
    end else if (cs_s) begin
      st <= fsid_pkg::DS_OPC;
      tot <= 6'h0;
    end else if (sclk_rise) begin
      tot <= (tot == 6'h3f) ? tot : tot + 6'h1;
      case (st)
        fsid_pkg::DS_OPC: begin
          op <= op_next;
          if (tot == 6'(fsid_pkg::OPCODE_BITS - 1)) begin
            st <= dec_st;
            cnt <= dec_cnt;
            lanes <= dec_lanes;
          end
        end
        fsid_pkg::DS_ADDR: begin
          case (lanes)
            3'h2: addr <= {addr[21:0], sio_s[1:0]};
            3'h4: addr <= {addr[19:0], sio_s[3:0]};
            default: addr <= {addr[22:0], sio_s[0]};
          endcase
          cnt <= cnt - 5'(lanes);
          if (cnt == 5'(lanes)) begin
            if (op == fsid_pkg::SECURE_AREA_READ_CMD) begin
              st <= fsid_pkg::DS_DUMMY;
              cnt <= 5'(fsid_pkg::DUMMY_BITS);
            end else begin
              st <= fsid_pkg::DS_DATA;
            end
          end
        end
        fsid_pkg::DS_DUMMY: begin
          cnt <= cnt - 5'h1;
          if (cnt == 5'h1) begin
            st <= fsid_pkg::DS_DATA;
          end
        end
        default: begin
          st <= st;
        end
      endcase
    end else if (sclk_fall && st == fsid_pkg::DS_DATA && bits_left == 4'h0 &&
                 op == fsid_pkg::SECURE_AREA_READ_CMD) begin
      addr[9:0] <= addr[9:0] + 10'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output byte source
  // register select
  assign sec_hit = addr[23:16] == fsid_pkg::SEC_TOP_BYTE &&
                   addr[15:12] >= fsid_pkg::SEC_SEL_FIRST &&
                   addr[15:12] <= fsid_pkg::SEC_SEL_LAST &&
                   addr[11:10] == fsid_pkg::SEC_GAP_BITS;
  assign sec_sel = addr[13:12] - 2'h1;

  always_comb begin
    out_byte = 8'hff;
    case (op)
      fsid_pkg::SECURE_AREA_READ_CMD: begin
        if (sec_hit) begin
          out_byte = sec_mem[{sec_sel, addr[9:0]}];
        end
      end
      fsid_pkg::WAKE_FROM_SLEEP_CMD: out_byte = SIG_ID;
      fsid_pkg::MAKER_DEVICE_ID_CMD,
      fsid_pkg::MAKER_DEVICE_ID_DUAL_CMD,
      fsid_pkg::MAKER_DEVICE_ID_QUAD_CMD: begin
        out_byte = (id_alt ^ addr[0]) ? DEV_ID : MAKER_ID;
      end
      fsid_pkg::THREE_BYTE_IDENT_CMD: begin
        case (byte_cnt)
          2'h0: out_byte = MAKER_ID;
          2'h1: out_byte = MEM_TYPE;
          2'h2: out_byte = DENSITY;
          default: out_byte = 8'hff;
        endcase
      end
      default: out_byte = 8'hff;
    endcase
  end

  // preload port for register contents
  always_ff @(posedge core_clk) begin
    if (load_en) begin
      sec_mem[load_addr] <= load_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // falling edge output shifter
  function automatic logic [7:0] drive(input logic [2:0] n, input logic [7:0] v);
    case (n)
      3'h2: drive = {4'hc, 2'h0, v[7:6]};
      3'h4: drive = {4'h0, v[7:4]};
      default: drive = {4'hd, 2'h0, v[7], 1'b0};
    endcase
  endfunction : drive

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.dev_sio_oe_n <= fsid_pkg::SIO_OE_N_IDLE;
      link.dev_sio_o <= fsid_pkg::SIO_OUT_IDLE;
      shreg <= 8'h00;
      bits_left <= 4'h0;
      byte_cnt <= 2'h0;
      id_alt <= 1'b0;
    end else if (cs_s || st != fsid_pkg::DS_DATA) begin
      link.dev_sio_oe_n <= fsid_pkg::SIO_OE_N_IDLE;
      bits_left <= 4'h0;
      byte_cnt <= 2'h0;
      id_alt <= 1'b0;
    end else if (sclk_fall) begin
      if (bits_left == 4'h0) begin
        {link.dev_sio_oe_n, link.dev_sio_o} <= drive(lanes, out_byte);
        shreg <= out_byte << lanes;
        bits_left <= 4'h8 - 4'(lanes);
        byte_cnt <= (byte_cnt == 2'h3) ? byte_cnt : byte_cnt + 2'h1;
        id_alt <= ~id_alt;
      end else begin
        {link.dev_sio_oe_n, link.dev_sio_o} <= drive(lanes, shreg);
        shreg <= shreg << lanes;
        bits_left <= bits_left - 4'(lanes);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state
  // reset lands in standby
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      asleep <= 1'b0;
      power_changing <= 1'b0;
      waking <= 1'b0;
      armed <= 1'b0;
      timer <= '0;
    end else begin
      if (timer != '0) begin
        timer <= timer - 1'b1;
      end
      if (timer == 1 && !waking) begin
        asleep <= 1'b1;
        power_changing <= 1'b0;
      end
      if (timer == 1 && waking) begin
        asleep <= 1'b0;
        power_changing <= 1'b0;
        waking <= 1'b0;
      end
      if (cs_rise) begin
        armed <= op == fsid_pkg::SOFT_RESET_ARM_CMD && tot == 6'(fsid_pkg::OPCODE_BITS);
        if (op == fsid_pkg::DEEP_SLEEP_CMD && tot == 6'(fsid_pkg::OPCODE_BITS) &&
            !asleep && !power_changing) begin
          timer <= ENTRY_CYC[fsid_pkg::TIMER_W-1:0];
          power_changing <= 1'b1;
          waking <= 1'b0;
        end
        if (op == fsid_pkg::WAKE_FROM_SLEEP_CMD && asleep && !waking &&
            (tot == 6'(fsid_pkg::OPCODE_BITS) || tot >= 6'(fsid_pkg::SIG_MIN_BITS))) begin
          timer <= EXIT_CYC[fsid_pkg::TIMER_W-1:0];
          power_changing <= 1'b1;
          waking <= 1'b1;
        end
        // soft reset pair wakes at once
        if (op == fsid_pkg::SOFT_RESET_GO_CMD && tot == 6'(fsid_pkg::OPCODE_BITS) && armed) begin
          asleep <= 1'b0;
          power_changing <= 1'b0;
          waking <= 1'b0;
          timer <= '0;
        end
      end
    end
  end

endmodule : fsid_dev

// ===== logic/fsid_host.sv
`timescale 1ns/100ps
module fsid_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_ptr, rd_ptr;

  // full when pointers differ only in wrap bit
  assign in_ready = !(wr_ptr[AW] != rd_ptr[AW] && wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : fsid_fifo

module fsid_host #(
  parameter int LEN_W = 12,
  parameter int FIFO_DEPTH = 32,
  parameter int HALF_CYC = fsid_pkg::SCLK_HALF_CYC,
  parameter int ENTRY_CYC = fsid_pkg::SLEEP_ENTRY_CYC,
  parameter int EXIT_CYC = fsid_pkg::WAKE_EXIT_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  fsid_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic [LEN_W-1:0] cmd_len,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);
  fsid_pkg::fsid_host_st_t st;
  logic [3:0] sio_m, sio_s;
  logic [7:0] half_cnt, cur_op, rx_sh, push_data;
  logic [31:0] tx_sh;
  logic [15:0] clk_i, total, a_end, tx_end, gap_cnt;
  logic [2:0] al, rl;
  logic [3:0] rx_bits;
  logic push, push_ready, stall, tick;
  logic [5:0] aclk, dclk;
  logic rx_on;

  ////////////////////////////////////////////////////////////////////////////
  // command shape per opcode
  always_comb begin
    aclk = 6'h0;
    dclk = 6'h0;
    al = 3'h1;
    rx_on = 1'b1;
    case (cmd_op)
      fsid_pkg::SECURE_AREA_READ_CMD: begin
        aclk = 6'(fsid_pkg::ADDR_BITS);
        dclk = 6'(fsid_pkg::DUMMY_BITS);
      end
      fsid_pkg::MAKER_DEVICE_ID_CMD: aclk = 6'(fsid_pkg::ADDR_BITS);
      fsid_pkg::MAKER_DEVICE_ID_DUAL_CMD: begin
        aclk = 6'(fsid_pkg::ADDR_BITS / 2);
        al = 3'h2;
      end
      fsid_pkg::MAKER_DEVICE_ID_QUAD_CMD: begin
        aclk = 6'(fsid_pkg::ADDR_BITS / 4);
        al = 3'h4;
      end
      // bare opcode wakes, else signature read
      fsid_pkg::WAKE_FROM_SLEEP_CMD: begin
        dclk = (cmd_len == '0) ? 6'h0 : 6'(fsid_pkg::SIG_DUMMY_BITS);
      end
      fsid_pkg::THREE_BYTE_IDENT_CMD: rx_on = 1'b1;
      default: rx_on = 1'b0;
    endcase
  end

  assign cmd_ready = st == fsid_pkg::HS_IDLE;
  // back-pressure: once the command and dummy bits are out, the link clock halts while the buffer is full
  assign stall = clk_i >= tx_end && !push_ready;
  assign tick = st == fsid_pkg::HS_RUN && !stall && half_cnt == 8'(HALF_CYC - 1);

  // data from the device passes two flops
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sio_m <= 4'h0;
      sio_s <= 4'h0;
    end else begin
      sio_m <= link.sio;
      sio_s <= sio_m;
    end
  end

  // link clock divider
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_cnt <= 8'h0;
    end else if (st != fsid_pkg::HS_RUN || tick) begin
      half_cnt <= 8'h0;
    end else if (!stall) begin
      half_cnt <= half_cnt + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= fsid_pkg::HS_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.host_sio_o <= fsid_pkg::SIO_OUT_IDLE;
      link.host_sio_oe_n <= fsid_pkg::SIO_OE_N_IDLE;
      tx_sh <= 32'h0;
      cur_op <= 8'h00;
      clk_i <= 16'h0;
      total <= 16'h0;
      a_end <= 16'h0;
      tx_end <= 16'h0;
      gap_cnt <= 16'h0;
      rl <= 3'h1;
      rx_sh <= 8'h00;
      rx_bits <= 4'h0;
      push <= 1'b0;
      push_data <= 8'h00;
    end else begin
      push <= 1'b0;
      case (st)
        fsid_pkg::HS_IDLE: begin
          if (cmd_valid) begin
            st <= fsid_pkg::HS_RUN;
            link.cs_n <= 1'b0;
            link.host_sio_o <= {3'h0, cmd_op[7]};
            link.host_sio_oe_n <= 4'he;
            tx_sh <= {cmd_op[6:0], cmd_addr, 1'b0};
            cur_op <= cmd_op;
            clk_i <= 16'h0;
            a_end <= 16'(fsid_pkg::OPCODE_BITS) + 16'(aclk);
            tx_end <= 16'(fsid_pkg::OPCODE_BITS) + 16'(aclk) + 16'(dclk);
            total <= 16'(fsid_pkg::OPCODE_BITS) + 16'(aclk) + 16'(dclk) +
                     (rx_on ? 16'((cmd_len * 8) / al) : 16'h0);
            rl <= al;
            rx_bits <= 4'h0;
          end
        end
        fsid_pkg::HS_RUN: begin
          if (tick && !link.sclk) begin
            link.sclk <= 1'b1;
            clk_i <= clk_i + 16'h1;
          end else if (tick) begin
            link.sclk <= 1'b0;
            // sample just before the fall, device data settled since last fall
            if (clk_i > tx_end) begin
              case (rl)
                3'h2: rx_sh <= {rx_sh[5:0], sio_s[1:0]};
                3'h4: rx_sh <= {rx_sh[3:0], sio_s[3:0]};
                default: rx_sh <= {rx_sh[6:0], sio_s[1]};
              endcase
              if (rx_bits == 4'h8 - 4'(rl)) begin
                push <= 1'b1;
                case (rl)
                  3'h2: push_data <= {rx_sh[5:0], sio_s[1:0]};
                  3'h4: push_data <= {rx_sh[3:0], sio_s[3:0]};
                  default: push_data <= {rx_sh[6:0], sio_s[1]};
                endcase
                rx_bits <= 4'h0;
              end else begin
                rx_bits <= rx_bits + 4'(rl);
              end
            end
            if (clk_i == total) begin
              // select rises right at byte end
              link.cs_n <= 1'b1;
              link.host_sio_oe_n <= fsid_pkg::SIO_OE_N_IDLE;
              st <= fsid_pkg::HS_GAP;
              // hold select high through wake delay, plus far-end sync lag
              gap_cnt <= (cur_op == fsid_pkg::WAKE_FROM_SLEEP_CMD) ? 16'(EXIT_CYC + 4) :
                         (cur_op == fsid_pkg::DEEP_SLEEP_CMD) ? 16'(ENTRY_CYC) :
                         16'(fsid_pkg::CS_HIGH_MIN_CYC);
            end else if (clk_i < a_end && clk_i >= 16'(fsid_pkg::OPCODE_BITS) && rl != 3'h1) begin
              {link.host_sio_oe_n, link.host_sio_o} <= (rl == 3'h2) ?
                  {4'hc, 2'h0, tx_sh[31:30]} : {4'h0, tx_sh[31:28]};
              tx_sh <= tx_sh << rl;
            end else if (clk_i < a_end) begin
              link.host_sio_o <= {3'h0, tx_sh[31]};
              link.host_sio_oe_n <= 4'he;
              tx_sh <= tx_sh << 1;
            end else if (clk_i < tx_end) begin
              link.host_sio_o <= 4'h0;
              link.host_sio_oe_n <= 4'he;
            end else begin
              link.host_sio_oe_n <= fsid_pkg::SIO_OE_N_IDLE;
            end
          end
        end
        fsid_pkg::HS_GAP: begin
          if (gap_cnt <= 16'h1) begin
            st <= fsid_pkg::HS_IDLE;
          end else begin
            gap_cnt <= gap_cnt - 16'h1;
          end
        end
        default: st <= fsid_pkg::HS_IDLE;
      endcase
    end
  end

  fsid_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

endmodule : fsid_host

// ===== logic/fsid_link_if.sv
`timescale 1ns/100ps
interface fsid_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] host_sio_o;
  logic [3:0] host_sio_oe_n;
  logic [3:0] dev_sio_o;
  logic [3:0] dev_sio_oe_n;
  logic [3:0] sio;
  logic [3:0] sio_clash;

  // wire level: driven value, else pulled high
  assign sio = (~host_sio_oe_n & host_sio_o) | (~dev_sio_oe_n & dev_sio_o) |
               (host_sio_oe_n & dev_sio_oe_n);
  assign sio_clash = ~host_sio_oe_n & ~dev_sio_oe_n;

  modport dev (input cs_n, input sclk, input sio, output dev_sio_o, output dev_sio_oe_n);
  modport host (output cs_n, output sclk, output host_sio_o, output host_sio_oe_n,
                input sio);
endinterface : fsid_link_if

// ===== logic/fsid_pkg.sv
package fsid_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [7:0] SECURE_AREA_READ_CMD = 8'h48;
  localparam logic [7:0] DEEP_SLEEP_CMD = 8'hb9;
  localparam logic [7:0] WAKE_FROM_SLEEP_CMD = 8'hab;
  localparam logic [7:0] MAKER_DEVICE_ID_CMD = 8'h90;
  localparam logic [7:0] MAKER_DEVICE_ID_DUAL_CMD = 8'h92;
  localparam logic [7:0] MAKER_DEVICE_ID_QUAD_CMD = 8'h94;
  localparam logic [7:0] THREE_BYTE_IDENT_CMD = 8'h9f;
  localparam logic [7:0] SOFT_RESET_ARM_CMD = 8'h66;
  localparam logic [7:0] SOFT_RESET_GO_CMD = 8'h99;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout in bits and register select fields
  localparam int OPCODE_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int DUMMY_BITS = 8;
  localparam int SIG_DUMMY_BITS = 24;
  localparam int SIG_MIN_BITS = 40;
  localparam logic [7:0] SEC_TOP_BYTE = 8'h00;
  localparam logic [3:0] SEC_SEL_FIRST = 4'h1;
  localparam logic [3:0] SEC_SEL_LAST = 4'h3;
  localparam logic [1:0] SEC_GAP_BITS = 2'h0;
  localparam int SEC_ENTRIES = 3072;
  localparam int SEC_IDX_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CORE_CLK_MHZ = 40;
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int WAKE_EXIT_DELAY_NS = 8000;
  localparam int WAKE_EXIT_CYC = (WAKE_EXIT_DELAY_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int CS_HIGH_MIN_NS = 50;
  localparam int CS_HIGH_MIN_CYC = (CS_HIGH_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int SCLK_HALF_CYC = 4;
  localparam int TIMER_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [3:0] SIO_OE_N_IDLE = 4'hf;
  localparam logic [3:0] SIO_OUT_IDLE = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // states
  typedef enum logic [2:0] {
    DS_OPC = 3'h0,
    DS_ADDR = 3'h1,
    DS_DUMMY = 3'h3,
    DS_DATA = 3'h2,
    DS_IGNORE = 3'h6
  } fsid_dev_st_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_RUN = 2'h1,
    HS_GAP = 2'h3
  } fsid_host_st_t;

endpackage : fsid_pkg
